// ### rtl/rxdso_defs.vh
// constants for the receive deserializer and five-times oversampler
// assumes byte addresses on a 32-bit register bus, one word per register
`ifndef RXDSO_DEFS_VH
`define RXDSO_DEFS_VH
// register byte offsets
`define RXDSO_CTRL_OFF    8'h00
`define RXDSO_RESET_OFF   8'h04
`define RXDSO_STATUS_OFF  8'h08
`define RXDSO_UDIV_OFF    8'h0C
`define RXDSO_TUNE_OFF    8'h10
// control register fields
`define RXDSO_CTRL_OS     0
`define RXDSO_CTRL_WIDE   1
`define RXDSO_CTRL_TRACK  2
`define RXDSO_CTRL_DIV_LO 4
`define RXDSO_CTRL_URUN   8
`define RXDSO_CTRL_RST    32'h0000_0104
// reset register fields, write one to pulse
`define RXDSO_RST_PCS_LO  0
`define RXDSO_RST_CDR_LO  8
// status register fields
`define RXDSO_STAT_ERR_LO 0
`define RXDSO_STAT_PH_LO  8
// user clock divider and tuning word reset values
`define RXDSO_UDIV_RST    16'h0009
`define RXDSO_TUNE_RST    25'h0000000
// datapath figures
`define RXDSO_LAST_W16    4'h7
`define RXDSO_LAST_W20    4'h9
`define RXDSO_PHASE_RST   3'h2
`endif

// ### rtl/rxdso_deser.v
// serial to parallel converter, two line bits per line-rate step
// assumes bit_en_in marks each line-rate step, pair bit 0 is the older bit
`timescale 1ns/100ps
`include "rxdso_defs.vh"
module rxdso_deser (
  input  wire        clk_sys_in,     // system clock
  input  wire        rstn_in,        // async reset, active low
  input  wire        restart_in,     // clock recovery reset pulse
  input  wire        bit_en_in,      // line-rate step strobe
  input  wire [1:0]  serial_pair_in, // bits of rising and falling edge
  input  wire        wide_in,        // high for 20-bit words
  output reg  [19:0] word_out,       // parallel word, oldest bit in bit 0
  output reg         word_valid_out  // one pulse per parallel-side clock
);
  reg  [19:0] shift_q;
  reg  [3:0]  cnt_q;
  wire [19:0] shift_d = {serial_pair_in, shift_q[19:2]};
  wire [3:0]  last    = wide_in ? `RXDSO_LAST_W20 : `RXDSO_LAST_W16;

  // shift both edge bits in, emit a word every width/2 steps
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift_q        <= 20'h00000;
      cnt_q          <= 4'h0;
      word_out       <= 20'h00000;
      word_valid_out <= 1'b0;
    end else if (restart_in) begin
      cnt_q          <= 4'h0;
      word_valid_out <= 1'b0;
    end else begin
      word_valid_out <= 1'b0;
      if (bit_en_in) begin
        shift_q <= shift_d;                                      // [RL3]
        if (cnt_q == last) begin                                 // [RL5]
          cnt_q          <= 4'h0;
          word_valid_out <= 1'b1;
          word_out       <= wide_in ? shift_d : {4'h0, shift_d[19:4]}; // [RL1]
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule // rxdso_deser

// ### rtl/rxdso_ovs.v
// five-times oversampler: 20 samples in, 4 data bits out
// assumes 20-bit words with the oldest sample in bit 0
`timescale 1ns/100ps
`include "rxdso_defs.vh"
module rxdso_ovs (
  input  wire        clk_sys_in,       // system clock
  input  wire        rstn_in,          // async reset, active low
  input  wire        restart_in,       // clock recovery reset pulse
  input  wire        track_in,         // sample point tracking enable
  input  wire [19:0] word_in,          // oversampled word
  input  wire        word_valid_in,    // word strobe
  output reg  [3:0]  nibble_out,       // recovered data, oldest in bit 0
  output reg         nibble_valid_out, // one pulse per word
  output reg  [2:0]  phase_out         // current sample point 0..4
);
  reg         prev_q;
  reg  [2:0]  best;
  reg  [2:0]  bmax;
  reg  [2:0]  center;
  wire [19:0] trans;
  wire [2:0]  bcnt [0:4];
  wire [19:0] picked = word_in >> phase_out;
  integer     k;

  // transition flags, bit 0 against the prior word's last sample
  genvar i;
  generate
    for (i = 0; i < 20; i = i + 1) begin : g_tr
      if (i == 0) begin : g_first
        assign trans[i] = word_in[0] ^ prev_q;
      end else begin : g_rest
        assign trans[i] = word_in[i] ^ word_in[i-1];
      end
    end
    for (i = 0; i < 5; i = i + 1) begin : g_bk
      assign bcnt[i] = {2'h0, trans[i]} + {2'h0, trans[i+5]}
                     + {2'h0, trans[i+10]} + {2'h0, trans[i+15]};
    end
  endgenerate

  // strongest edge phase, sample point sits two samples past it
  always @* begin
    best = 3'h0;
    bmax = bcnt[0];
    for (k = 1; k < 5; k = k + 1) begin
      if (bcnt[k] > bmax) begin
        bmax = bcnt[k];
        best = k[2:0];
      end
    end
    case (best)
      3'h0:    center = 3'h2;
      3'h1:    center = 3'h3;
      3'h2:    center = 3'h4;
      3'h3:    center = 3'h0;
      default: center = 3'h1;
    endcase
  end

  // pick one sample in five, move the point only while tracking
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev_q           <= 1'b0;
      nibble_out       <= 4'h0;
      nibble_valid_out <= 1'b0;
      phase_out        <= `RXDSO_PHASE_RST;
    end else if (restart_in) begin
      nibble_valid_out <= 1'b0;
      phase_out        <= `RXDSO_PHASE_RST;
    end else begin
      nibble_valid_out <= word_valid_in;
      if (word_valid_in) begin
        prev_q     <= word_in[19];
        nibble_out <= {picked[15], picked[10], picked[5], picked[0]}; // [RL7]
        if (track_in && (|trans))                                     // [RL15]
          phase_out <= center;                                        // [RL7]
      end
    end
  end
endmodule // rxdso_ovs

// ### rtl/rxdso_top.v
// receive deserializer with five-times oversampler for a two-lane tile
// assumes an AXI4-Lite master on the register side and line bits
// arriving synchronous to clk_sys_in, two bits per clock at full rate
//
// Overview of operation
// [RL1] without oversampling width select gives 16/20 bits
// [RL2] oversampling forces the 20-bit datapath
// [RL3] deserializer takes bits on both clock edges
// [RL4] line rate is twice pll clock over divider
// [RL5] parallel clock is line rate over width
// [RL6] serial and parallel clocks come from recovery
// [RL7] oversampler yields four bits per twenty samples
// [RL8] integrator sets line rate to five times data
// [RL9] integrator keeps pll clock inside its range
// [RL10] pll clock from reference and divider ratio
// [RL11] oversampled words arrive at line rate over 20
// [RL12] oversampler output feeds pcs at user clock
// [RL13] user clock sums use the desired rate
// [RL14] oversampling enable covers both tile lanes
// [RL15] tracking moves sample point, else it holds
// [RL16] buffer overflow or underflow raises error output
// [RL17] pcs or recovery reset clears the error
// [RL18] tracking input is best tied high
// [RL19] tuning word default, or 0F44000 when oversampling
// [RL20] line-rate divider is one, two or four
// [RL21] error stays high until a clearing reset
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "rxdso_defs.vh"
module rxdso_top #(
  parameter LANES  = 2, // lanes in the tile
  parameter FIFO_D = 8, // oversampler buffer depth
  parameter FIFO_A = 3  // log2 of FIFO_D
) (
  input  wire                clk_sys_in,               // system clock, 100 MHz
  input  wire                rstn_in,                  // async reset, active low
  input  wire [7:0]          s_axi_awaddr,             // write address
  input  wire                s_axi_awvalid,            // write address valid
  output reg                 s_axi_awready,            // write address ready
  input  wire [31:0]         s_axi_wdata,              // write data
  input  wire [3:0]          s_axi_wstrb,              // write byte strobes
  input  wire                s_axi_wvalid,             // write data valid
  output reg                 s_axi_wready,             // write data ready
  output reg  [1:0]          s_axi_bresp,              // write response
  output reg                 s_axi_bvalid,             // write response valid
  input  wire                s_axi_bready,             // write response ready
  input  wire [7:0]          s_axi_araddr,             // read address
  input  wire                s_axi_arvalid,            // read address valid
  output reg                 s_axi_arready,            // read address ready
  output reg  [31:0]         s_axi_rdata,              // read data
  output reg  [1:0]          s_axi_rresp,              // read response
  output reg                 s_axi_rvalid,             // read data valid
  input  wire                s_axi_rready,             // read data ready
  input  wire [2*LANES-1:0]  rx_serial_in,             // two line bits per lane
  output reg  [20*LANES-1:0] rx_data_out,              // pcs data per lane
  output reg  [LANES-1:0]    rx_valid_out,             // pcs data strobe per lane
  output reg  [LANES-1:0]    sampler_buffer_error_out, // buffer error per lane
  output reg  [24:0]         recovery_tuning_word_out  // tuning word to recovery
);
  localparam [1:0] RESP_OK  = 2'h0;
  localparam [1:0] RESP_ERR = 2'h2;

  // register state
  reg  [31:0]      ctrl_q;
  reg  [15:0]      udiv_q;
  reg  [LANES-1:0] pcs_rst_q;
  reg  [LANES-1:0] cdr_rst_q;
  // bus state
  reg              aw_have_q;
  reg              w_have_q;
  reg  [7:0]       awaddr_q;
  reg  [31:0]      wdata_q;
  reg  [3:0]       wstrb_q;
  reg  [31:0]      rd_val;
  reg              rd_hit;
  // clock strobes
  reg  [1:0]       dcnt_q;
  reg  [1:0]       dlast;
  reg  [15:0]      ucnt_q;
  wire             wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire             wr_hit  = (awaddr_q == `RXDSO_CTRL_OFF)  || (awaddr_q == `RXDSO_RESET_OFF)
                          || (awaddr_q == `RXDSO_UDIV_OFF)  || (awaddr_q == `RXDSO_TUNE_OFF);
  wire             os_en   = ctrl_q[`RXDSO_CTRL_OS];
  wire             wide    = os_en | ctrl_q[`RXDSO_CTRL_WIDE];
  wire             track   = ctrl_q[`RXDSO_CTRL_TRACK];
  wire             urun    = ctrl_q[`RXDSO_CTRL_URUN];
  wire [1:0]       divsel  = ctrl_q[`RXDSO_CTRL_DIV_LO+1:`RXDSO_CTRL_DIV_LO];
  wire             bit_en  = (dcnt_q == dlast);
  wire             utick   = (ucnt_q == udiv_q);
  wire [3*LANES-1:0] phase;

  // merge write data into a register under the byte strobes
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b])
          wmerge[8*b +: 8] = data[8*b +: 8];
      end
    end
  endfunction
  // merged writes
  wire [31:0] udiv_m = wmerge({16'h0000, udiv_q}, wdata_q, wstrb_q);
  wire [31:0] tune_m = wmerge({7'h00, recovery_tuning_word_out}, wdata_q, wstrb_q);

  // write channels: address and data taken in either order
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        awaddr_q      <= {s_axi_awaddr[7:2], 2'h0};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OK : RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // register writes; reset bits pulse one cycle
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q                   <= `RXDSO_CTRL_RST;
      udiv_q                   <= `RXDSO_UDIV_RST;
      recovery_tuning_word_out <= `RXDSO_TUNE_RST;
      pcs_rst_q                <= {LANES{1'b0}};
      cdr_rst_q                <= {LANES{1'b0}};
    end else begin
      pcs_rst_q <= {LANES{1'b0}};
      cdr_rst_q <= {LANES{1'b0}};
      if (wr_fire) begin
        case (awaddr_q)
          `RXDSO_CTRL_OFF: ctrl_q <= wmerge(ctrl_q, wdata_q, wstrb_q); // [RL14]
          `RXDSO_RESET_OFF: begin
            pcs_rst_q <= wdata_q[`RXDSO_RST_PCS_LO +: LANES] & {LANES{wstrb_q[0]}};
            cdr_rst_q <= wdata_q[`RXDSO_RST_CDR_LO +: LANES] & {LANES{wstrb_q[1]}};
          end
          `RXDSO_UDIV_OFF: udiv_q <= udiv_m[15:0];
          `RXDSO_TUNE_OFF: recovery_tuning_word_out <= tune_m[24:0]; // [RL19]
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  // read decode
  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      `RXDSO_CTRL_OFF:   rd_val = ctrl_q;
      `RXDSO_RESET_OFF:  rd_val = 32'h0000_0000;
      `RXDSO_STATUS_OFF: begin
        rd_val[`RXDSO_STAT_ERR_LO +: LANES]  = sampler_buffer_error_out;
        rd_val[`RXDSO_STAT_PH_LO +: 3*LANES] = phase;
      end
      `RXDSO_UDIV_OFF:   rd_val = {16'h0000, udiv_q};
      `RXDSO_TUNE_OFF:   rd_val = {7'h00, recovery_tuning_word_out};
      default:           rd_hit = 1'b0;
    endcase
  end

  // read channel, answer one edge after the take
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // line-rate step: two bits per step, one step every divider clocks;
  // code 3 acts as four
  always @* begin
    case (divsel)
      2'h0:    dlast = 2'h0;
      2'h1:    dlast = 2'h1;
      default: dlast = 2'h3;
    endcase
  end

  // divider counter and pcs user clock counter
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dcnt_q <= 2'h0;
      ucnt_q <= 16'h0000;
    end else begin
      dcnt_q <= bit_en ? 2'h0 : dcnt_q + 2'h1;                 // [RL4] [RL6]
      ucnt_q <= (utick || !urun) ? 16'h0000 : ucnt_q + 16'h0001;
    end
  end

  // per lane: deserializer, oversampler, buffer, output
  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1) begin : g_lane
      wire [19:0]      word;
      wire             word_v;
      wire [3:0]       nib;
      wire             nib_v;
      reg  [3:0]       mem [0:FIFO_D-1];
      reg  [FIFO_A:0]  wp_q;
      reg  [FIFO_A:0]  rp_q;
      reg              primed_q;
      wire             full  = (wp_q[FIFO_A] != rp_q[FIFO_A])
                            && (wp_q[FIFO_A-1:0] == rp_q[FIFO_A-1:0]);
      wire             empty = (wp_q == rp_q);
      wire             wr    = os_en && nib_v;
      wire             rd    = os_en && urun && utick;
      wire             ovf   = wr && full;
      wire             udf   = rd && empty && primed_q;

      rxdso_deser u_deser (
        .clk_sys_in     (clk_sys_in),
        .rstn_in        (rstn_in),
        .restart_in     (cdr_rst_q[l]),
        .bit_en_in      (bit_en),
        .serial_pair_in (rx_serial_in[2*l +: 2]),
        .wide_in        (wide),                                     // [RL2]
        .word_out       (word),
        .word_valid_out (word_v)
      );

      rxdso_ovs u_ovs (
        .clk_sys_in       (clk_sys_in),
        .rstn_in          (rstn_in),
        .restart_in       (cdr_rst_q[l]),
        .track_in         (track),
        .word_in          (word),
        .word_valid_in    (word_v && os_en),                        // [RL11]
        .nibble_out       (nib),
        .nibble_valid_out (nib_v),
        .phase_out        (phase[3*l +: 3])
      );

      // buffer storage
      always @(posedge clk_sys_in) begin
        if (wr && !full)
          mem[wp_q[FIFO_A-1:0]] <= nib;
      end

      // buffer pointers, flushed by the pcs reset
      always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          wp_q     <= {(FIFO_A+1){1'b0}};
          rp_q     <= {(FIFO_A+1){1'b0}};
          primed_q <= 1'b0;
        end else if (pcs_rst_q[l]) begin
          wp_q     <= {(FIFO_A+1){1'b0}};
          rp_q     <= {(FIFO_A+1){1'b0}};
          primed_q <= 1'b0;
        end else begin
          if (wr && !full) begin
            wp_q     <= wp_q + 1'b1;
            primed_q <= 1'b1;
          end
          if (rd && !empty)
            rp_q <= rp_q + 1'b1;
        end
      end

      // sticky error; a new fault in the clearing cycle wins
      always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in)
          sampler_buffer_error_out[l] <= 1'b0;
        else if (ovf || udf)
          sampler_buffer_error_out[l] <= 1'b1;                      // [RL16] [RL21]
        else if (pcs_rst_q[l] || cdr_rst_q[l])
          sampler_buffer_error_out[l] <= 1'b0;                      // [RL17]
      end

      // pcs side: raw words or nibbles on user ticks
      always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          rx_data_out[20*l +: 20] <= 20'h00000;
          rx_valid_out[l]         <= 1'b0;
        end else if (!os_en) begin
          rx_valid_out[l] <= word_v;                                // [RL5]
          if (word_v)
            rx_data_out[20*l +: 20] <= word;                        // [RL1]
        end else begin
          rx_valid_out[l] <= rd && !empty;                          // [RL12]
          if (rd && !empty)
            rx_data_out[20*l +: 20] <= {16'h0000, mem[rp_q[FIFO_A-1:0]]};
        end
      end
    end
  endgenerate
endmodule // rxdso_top

// ### dv/rxdso_properties.sv
// checker on the top ports
// assumes a bind to rxdso_top, one clock, async active-low reset
`timescale 1ns/100ps
module rxdso_chk #(
  parameter LANES = 2 // lanes
) (
  input wire             clk_sys_in,               // clock
  input wire             rstn_in,                  // reset
  input wire             s_axi_awvalid,            // aw valid
  input wire             s_axi_awready,            // aw ready
  input wire             s_axi_wvalid,             // w valid
  input wire             s_axi_wready,             // w ready
  input wire             s_axi_bvalid,             // b valid
  input wire             s_axi_bready,             // b ready
  input wire             s_axi_arvalid,            // ar valid
  input wire             s_axi_arready,            // ar ready
  input wire             s_axi_rvalid,             // r valid
  input wire             s_axi_rready,             // r ready
  input wire [LANES-1:0] rx_valid_out,             // word strobe
  input wire [LANES-1:0] sampler_buffer_error_out  // buffer error
);
  reg [5:0] gap_q; // cycles since last word
  // saturating count since last lane 0 word
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in)
      gap_q <= 6'h3F;
    else if (rx_valid_out[0])
      gap_q <= 6'h00;
    else if (gap_q != 6'h3F)
      gap_q <= gap_q + 6'h01;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // register bus answers and holds
  wr_resp_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("bvalid late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken early");
  rd_resp_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("rvalid late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  // a word needs eight steps at least
  word_gap_min_a: assert property (
    rx_valid_out[0] |-> gap_q >= 6'h07) else $error("words too close");
  // an error falls only after a reset write
  err_sticky_a: assert property (
    |($past(sampler_buffer_error_out) & ~sampler_buffer_error_out) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("error cleared alone");
endmodule // rxdso_chk

bind rxdso_top rxdso_chk #(.LANES(LANES)) u_chk (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_valid_out(rx_valid_out),
  .sampler_buffer_error_out(sampler_buffer_error_out)
);

// ### dv/rxdso_line_tx.sv
// model of the remote transmitter driving the receive line
// assumes the bench sets step length and pairs
`timescale 1ns/100ps
module rxdso_line_tx (
  input  wire       clk_sys_in, // clock
  input  wire       rstn_in,    // reset, active low
  input  wire [2:0] div_in,     // clocks per line step: 1, 2 or 4
  input  wire [3:0] pair_in,    // pair to send, two bits per lane
  output reg  [3:0] line_out    // line bits, two per lane
);
  reg [2:0] step_q; // clocks into step
  // hold each pair one step; the bench repeats levels when oversampling
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      step_q   <= 3'h0;
      line_out <= 4'h0;
    end else if (step_q + 3'h1 >= div_in) begin
      step_q   <= 3'h0;
      line_out <= pair_in;
    end else begin
      step_q <= step_q + 3'h1;
    end
  end
endmodule // rxdso_line_tx

// ### dv/tb_rx_deserializer_oversampler.sv
// self-checking bench for the receive deserializer
// assumes rxdso_top, its bound checker and the line model
`timescale 1ns/100ps
`include "rxdso_defs.vh"
module tb_rx_deserializer_oversampler;
  localparam [23:0] ROWS = 24'h836140; // {os, wide, divider code} per row
  typedef struct packed {
    logic [39:0] d; // data of both lanes
    logic [39:0] g; // gap in cycles
  } rxdso_exp_t;
  reg          clk_sys_in = 1'b0;
  reg          rstn_in = 1'b0;
  reg  [7:0]   aw_a = 8'h00, ar_a = 8'h00;
  reg  [31:0]  w_d = 32'h0000_0000;
  reg          aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  reg  [3:0]   pair = 4'h0;
  reg  [2:0]   div = 3'h1;
  wire         aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  wire [1:0]   b_resp, r_resp, rx_v, err;
  wire [31:0]  r_d;
  wire [3:0]   line;
  wire [39:0]  rx_d;
  wire [24:0]  tune;
  rxdso_exp_t  exp_q[$];
  rxdso_exp_t  it;
  integer      num_errors = 0, check_count = 0, cyc = 0, last_cyc = 0;
  integer      seed = 32'hAFE6687F, i, k, w, d;
  logic [3:0]  r, p;
  logic [39:0] e, g;
  // clock and parts
  always #5 clk_sys_in = ~clk_sys_in;
  rxdso_top dut (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .rx_serial_in(line),
    .rx_data_out(rx_d), .rx_valid_out(rx_v), .sampler_buffer_error_out(err),
    .recovery_tuning_word_out(tune));
  rxdso_line_tx u_line (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .div_in(div),
    .pair_in(pair), .line_out(line));
  // compare and count
  task check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // register write, response awaited
  task wr(input [7:0] a, input [31:0] dat, input [1:0] er);
    integer n;
    @(posedge clk_sys_in);
    aw_a <= a;
    w_d <= dat;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    for (n = 0; n < 50 && !b_v; n++) begin
      @(posedge clk_sys_in);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end
    check("bresp", {b_v, b_resp}, {1'b1, er});
    b_r <= 1'b0;
  endtask
  // register read and compare
  task rd(input [7:0] a, input [31:0] ex, input [1:0] er);
    integer n;
    @(posedge clk_sys_in);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    for (n = 0; n < 50 && !r_v; n++) begin
      @(posedge clk_sys_in);
      if (ar_rdy) ar_v <= 1'b0;
    end
    check("rdata", {r_v, r_resp, r_d}, {1'b1, er, ex});
    r_r <= 1'b0;
  endtask
  // bounded waits
  task wait_pulse(input integer cnt);
    integer n;
    for (n = 0; n < 2000 && cnt > 0; n++) begin
      @(posedge clk_sys_in);
      if (rx_v[0]) cnt--;
    end
  endtask
  task wait_err(input [1:0] ex, input integer lim);
    integer n;
    for (n = 0; n < lim && err !== ex; n++)
      @(posedge clk_sys_in);
    check("buf_err", err, ex);
  endtask
  // output watcher, oldest note first
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (rx_v[0]) begin
      if (exp_q.size() > 0) begin
        it = exp_q.pop_front();
        check("rx_data", rx_d, it.d);
        check("rx_gap", cyc - last_cyc, it.g);
        check("rx_lanes", rx_v, 2'h3);
      end
      last_cyc <= cyc;
    end
  end
  // watchdog
  initial begin
    #400000;
    num_errors++;
    end_sim;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rd(`RXDSO_CTRL_OFF, 32'h0000_0104, 2'h0);
    rd(`RXDSO_RESET_OFF, 32'h0000_0000, 2'h0);
    rd(`RXDSO_STATUS_OFF, 32'h0000_1200, 2'h0);
    rd(`RXDSO_UDIV_OFF, 32'h0000_0009, 2'h0);
    rd(`RXDSO_TUNE_OFF, 32'h0000_0000, 2'h0);
    rd(8'h14, 32'h0000_0000, 2'h2);
    wr(8'h14, 32'hFFFF_FFFF, 2'h2);
    $display("regs test done");
    for (i = 0; i < 6; i++) begin
      r = ROWS[4*i +: 4];
      w = (r[3] | r[2]) ? 20 : 16;
      d = (r[1:0] == 2'h0) ? 1 : (r[1:0] == 2'h1) ? 2 : 4;
      p = $random(seed);
      if (r[3]) p = {{2{p[2]}}, {2{p[0]}}};
      pair <= p;
      div <= d[2:0];
      wr(`RXDSO_CTRL_OFF, {23'h0, 1'h1, 2'h0, r[1:0], 2'h1, r[2], r[3]}, 2'h0);
      wr(`RXDSO_RESET_OFF, 32'h0000_0303, 2'h0);
      wait_pulse(3);
      e = 40'h0;
      for (k = 0; k < w; k += 2) begin
        e[k +: 2] = p[1:0];
        e[20 + k +: 2] = p[3:2];
      end
      if (r[3]) e = {16'h0, {4{p[2]}}, 16'h0, {4{p[0]}}};
      g = r[3] ? 10 : w / 2 * d;
      repeat (3) exp_q.push_back({e, g});
      for (k = 0; k < 2000 && exp_q.size() > 0; k++)
        @(posedge clk_sys_in);
      check("queue_left", exp_q.size(), 0);
      check("buf_err", err, 2'h0);
    end
    $display("rows test done");
    wr(`RXDSO_CTRL_OFF, 32'h0000_0005, 2'h0);
    wait_err(2'h3, 400);
    repeat (50) @(posedge clk_sys_in);
    check("err_held", err, 2'h3);
    rd(`RXDSO_STATUS_OFF, 32'h0000_1203, 2'h0);
    wr(`RXDSO_RESET_OFF, 32'h0000_0003, 2'h0);
    wait_err(2'h0, 6);
    div <= 3'h2;
    wr(`RXDSO_CTRL_OFF, 32'h0000_0115, 2'h0);
    wr(`RXDSO_RESET_OFF, 32'h0000_0003, 2'h0);
    wait_err(2'h0, 6);
    wait_err(2'h3, 400);
    wr(`RXDSO_RESET_OFF, 32'h0000_0300, 2'h0);
    wait_err(2'h0, 6);
    $display("error test done");
    div <= 3'h1;
    pair <= 4'h9;
    wr(`RXDSO_CTRL_OFF, 32'h0000_0101, 2'h0);
    wr(`RXDSO_RESET_OFF, 32'h0000_0303, 2'h0);
    repeat (200) @(posedge clk_sys_in);
    rd(`RXDSO_STATUS_OFF, 32'h0000_1200, 2'h0);
    $display("hold test done");
    e = {8'h00, $random(seed)};
    wr(`RXDSO_TUNE_OFF, e[31:0], 2'h0);
    check("tune", tune, e[24:0]);
    wr(`RXDSO_TUNE_OFF, 32'h00F4_4000, 2'h0);
    check("tune", tune, 25'h0F44000);
    $display("tune test done");
    end_sim;
  end
endmodule // tb_rx_deserializer_oversampler
